/* pkg/rmux_pkg.sv */
// constants shared by the relay multiplexer register ends
package rmux_pkg;
    localparam int unsigned  CLK_HZ          = 10000000;
    // read register numbers
    localparam logic [2:0]   RD_IDENT        = 3'h0;
    localparam logic [2:0]   RD_STATUS       = 3'h1;
    localparam logic [2:0]   RD_RELAY        = 3'h2;
    // write register numbers
    localparam logic [2:0]   WR_RESET        = 3'h0;
    localparam logic [2:0]   WR_OPEN         = 3'h3;
    localparam logic [2:0]   WR_CLOSE        = 3'h6;
    // status and command word fields
    localparam int unsigned  BUSY_BIT        = 1;
    localparam int unsigned  MASK_TREE_BIT   = 14;
    localparam int unsigned  MASK_BANKB_BIT  = 13;
    localparam int unsigned  MASK_BANKA_BIT  = 12;
    localparam int unsigned  TREE_LSB        = 8;
    localparam int unsigned  BANKB_LSB       = 4;
    localparam int unsigned  BANKA_LSB       = 0;
    localparam logic [3:0]   BANK_NONE       = 4'hc;
    localparam logic [15:0]  RELAY_RESET     = 16'h00cc;
    localparam logic [15:0]  ALL_ONES        = 16'hffff;
    localparam logic [2:0]   NO_TERMINAL     = 3'h7;
    // relay actuation time and settle wait
    localparam int unsigned  ACT_TIME_US     = 1000;
    localparam int unsigned  ACT_CYCLES      = (ACT_TIME_US * (CLK_HZ / 1000000));
    localparam int unsigned  SETTLE_TIME_US  = 1100;
    localparam int unsigned  SETTLE_CYCLES   = (SETTLE_TIME_US * (CLK_HZ / 1000000));
    localparam int unsigned  GAP_CYCLES      = 4;
    // controller command codes
    localparam logic [1:0]   CMD_READ        = 2'h0;
    localparam logic [1:0]   CMD_WRITE       = 2'h1;
    localparam logic [1:0]   CMD_IDENT       = 2'h2;
    // controller register numbers
    localparam logic [3:0]   CR_CMD          = 4'h0;
    localparam logic [3:0]   CR_DATA         = 4'h1;
    localparam logic [3:0]   CR_RESULT       = 4'h2;
    localparam logic [3:0]   CR_STATUS       = 4'h3;
    localparam logic [3:0]   CR_IDENT        = 4'h4;
endpackage

/* pkg/rmux_bus_if.sv */
// backplane link between the local controller and the relay accessory
`timescale 1ns/1ps
interface rmux_bus_if;
    logic [2:0]  reg_num;
    logic [15:0] wr_data;
    logic        wr_stb;
    logic        rd_stb;
    logic [15:0] rd_data;
    logic        opening_pulse;
    logic        closing_pulse;
    logic        slot_reset;
    modport accessory (input reg_num, input wr_data, input wr_stb, input rd_stb, input slot_reset,
                       output rd_data, output opening_pulse, output closing_pulse);
    modport controller (output reg_num, output wr_data, output wr_stb, output rd_stb, output slot_reset,
                        input rd_data, input opening_pulse, input closing_pulse);
endinterface

/* design/rmux_accessory.sv */
// relay multiplexer accessory: register decode and relay sequencing
//
// Overview of operation
// - separate read and write register decode
// - identity on low byte, high byte ones
// - five component bits, three terminal bits
// - controller reads identity, never gates commands
// - status bit one is busy
// - relay state on bits zero to eleven
// - empty bank reads binary 1100
// - closed channel digit in bank field
// - state updates after relay action done
// - controller waits before reading state
// - sixty channel: relay plus sense tree
// - sixty channel: closing bank A opens bank B
// - sixty channel: source tree is ninety-one
// - thermocouple variant reserves two trees
// - write zero resets all relays
// - mask bits enable tree, bank fields
// - tree bits eleven to eight map
// - close waits for opening pulse end; closing_pulse is raised while the close waits
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module rmux_accessory #(
    parameter logic [4:0]  COMPONENT_ID = 5'h15,  // arbitrary value
    parameter bit          SIXTY_CH     = 1'b0,
    parameter int unsigned ACT_CYCLES   = rmux_pkg::ACT_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       terminal_present,
    input  wire logic [2:0] terminal_id,
    rmux_bus_if.accessory   bus,
    output logic [3:0]      tree_drive,
    output logic [3:0]      bank_a_drive,
    output logic [3:0]      bank_b_drive,
    output logic            busy
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_OPEN  = 3'b010,
        ST_CLOSE = 3'b100
    } rmux_state_type;

    rmux_state_type state_r;
    logic [31:0]    timer_r;
    logic [15:0]    cmd_r;
    logic           close_pend_r;
    logic [15:0]    close_cmd_r;
    logic [15:0]    relay_state_r;
    logic [15:0]    relay_state_nxt;
    logic [15:0]    rd_data_r;
    logic [7:0]     ident;
    logic           soft_reset;
    logic           do_open;
    logic           do_close;
    logic           timer_done;
    logic           reset_write;
    logic [2:0]     term_code;
    logic [31:0]    reset_hold_r;

    // write strobe aimed at one write register
    function automatic logic wr_hit(input logic stb, input logic [2:0] num, input logic [2:0] want);
        logic hit;
        hit = stb && (num == want);
        return hit;
    endfunction

    // write decode and identity
    assign reset_write = wr_hit(bus.wr_stb, bus.reg_num, rmux_pkg::WR_RESET);
    assign soft_reset  = rst | bus.slot_reset | reset_write;
    assign do_open     = wr_hit(bus.wr_stb, bus.reg_num, rmux_pkg::WR_OPEN);
    assign do_close    = wr_hit(bus.wr_stb, bus.reg_num, rmux_pkg::WR_CLOSE);
    assign timer_done  = (timer_r == 32'h0);
    assign term_code   = terminal_present ? terminal_id : rmux_pkg::NO_TERMINAL;
    assign ident       = {COMPONENT_ID, term_code};

    // applies a command word to one four-bit field
    function automatic logic [3:0] apply_field(input logic [3:0] cur, input logic [3:0] cmd,
                                               input logic en, input logic close);
        logic [3:0] res;
        res = cur;
        if (en && close) begin
            res = cmd;
        end else if (en) begin
            res = rmux_pkg::BANK_NONE;
        end
        return res;
    endfunction

    // new relay state from a finished command
    always_comb begin
        relay_state_nxt = relay_state_r;
        relay_state_nxt[rmux_pkg::BANKA_LSB +: 4] = apply_field(relay_state_r[rmux_pkg::BANKA_LSB +: 4],
            cmd_r[rmux_pkg::BANKA_LSB +: 4], cmd_r[rmux_pkg::MASK_BANKA_BIT], state_r == ST_CLOSE);
        relay_state_nxt[rmux_pkg::BANKB_LSB +: 4] = apply_field(relay_state_r[rmux_pkg::BANKB_LSB +: 4],
            cmd_r[rmux_pkg::BANKB_LSB +: 4], cmd_r[rmux_pkg::MASK_BANKB_BIT], state_r == ST_CLOSE);
        if (cmd_r[rmux_pkg::MASK_TREE_BIT]) begin
            if (state_r == ST_CLOSE) begin
                relay_state_nxt[rmux_pkg::TREE_LSB +: 4] = relay_state_r[rmux_pkg::TREE_LSB +: 4]
                                                           | cmd_r[rmux_pkg::TREE_LSB +: 4];
            end else begin
                relay_state_nxt[rmux_pkg::TREE_LSB +: 4] = relay_state_r[rmux_pkg::TREE_LSB +: 4]
                                                           & ~cmd_r[rmux_pkg::TREE_LSB +: 4];
            end
        end
        if (SIXTY_CH && state_r == ST_CLOSE && cmd_r[rmux_pkg::MASK_BANKA_BIT]) begin
            // one channel at a time: other bank cleared, sense trees set from command bits
            relay_state_nxt[rmux_pkg::BANKB_LSB +: 4] = rmux_pkg::BANK_NONE;
            relay_state_nxt[rmux_pkg::TREE_LSB + 1 +: 3] = cmd_r[rmux_pkg::TREE_LSB + 1 +: 3];
        end
        relay_state_nxt[15:12] = 4'h0;
    end

    // opening and closing sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r      <= ST_IDLE;
            timer_r      <= 32'h0;
            cmd_r        <= 16'h0;
            close_pend_r <= 1'b0;
            close_cmd_r  <= 16'h0;
        end else if (soft_reset) begin
            state_r      <= ST_IDLE;
            timer_r      <= 32'h0;
            close_pend_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (do_open) begin
                        state_r <= ST_OPEN;
                        cmd_r   <= bus.wr_data;
                        timer_r <= ACT_CYCLES - 1;
                    end else if (do_close || close_pend_r) begin
                        state_r      <= ST_CLOSE;
                        cmd_r        <= close_pend_r ? close_cmd_r : bus.wr_data;
                        close_pend_r <= 1'b0;
                        timer_r      <= ACT_CYCLES - 1;
                    end
                end
                ST_OPEN: begin
                    if (do_close) begin
                        close_pend_r <= 1'b1;
                        close_cmd_r  <= bus.wr_data;
                    end
                    if (timer_done) begin
                        state_r <= ST_IDLE;
                    end else begin
                        timer_r <= timer_r - 32'h1;
                    end
                end
                ST_CLOSE: begin
                    if (timer_done) begin
                        state_r <= ST_IDLE;
                    end else begin
                        timer_r <= timer_r - 32'h1;
                    end
                end
            endcase
        end
    end

    // relay state register, written when the action completes and loaded with the reset value on any reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            relay_state_r <= rmux_pkg::RELAY_RESET;
        end else if (soft_reset) begin
            relay_state_r <= rmux_pkg::RELAY_RESET;
        end else if (state_r != ST_IDLE && timer_done) begin
            relay_state_r <= relay_state_nxt;
        end
    end

    // relays still dropping out for one action time after a slot reset or reset write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reset_hold_r <= 32'h0;
        end else if (soft_reset) begin
            reset_hold_r <= ACT_CYCLES;
        end else if (reset_hold_r != 32'h0) begin
            reset_hold_r <= reset_hold_r - 32'h1;
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data_r <= rmux_pkg::ALL_ONES;
        end else if (bus.rd_stb) begin
            unique case (bus.reg_num)
                rmux_pkg::RD_IDENT:  rd_data_r <= {8'hff, ident};
                rmux_pkg::RD_STATUS: rd_data_r <= {14'h0, busy, 1'b0};
                rmux_pkg::RD_RELAY:  rd_data_r <= relay_state_r;
                default:             rd_data_r <= rmux_pkg::ALL_ONES;
            endcase
        end
    end

    // link outputs and relay drives
    assign busy              = (state_r != ST_IDLE) || close_pend_r || (reset_hold_r != 32'h0);
    assign bus.rd_data       = rd_data_r;
    assign bus.opening_pulse = (state_r == ST_OPEN);
    assign bus.closing_pulse = (state_r == ST_CLOSE) || close_pend_r;
    assign tree_drive        = relay_state_r[rmux_pkg::TREE_LSB +: 4];
    assign bank_a_drive      = relay_state_r[rmux_pkg::BANKA_LSB +: 4];
    assign bank_b_drive      = relay_state_r[rmux_pkg::BANKB_LSB +: 4];
endmodule

/* design/rmux_controller.sv */
// local controller end: raw register access with busy and settle gating
`timescale 1ns/1ps
module rmux_controller #(
    parameter int unsigned SETTLE_CYCLES = rmux_pkg::SETTLE_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [15:0]      rdata,
    rmux_bus_if.controller   bus
);
    typedef enum logic [4:0] {
        CS_IDLE  = 5'b00001,
        CS_POLL  = 5'b00010,
        CS_PWAIT = 5'b00100,
        CS_ISSUE = 5'b01000,
        CS_WAIT  = 5'b10000
    } rmux_cstate_type;

    rmux_cstate_type state_r;
    logic [1:0]      cmd_r;
    logic [2:0]      reg_r;
    logic [15:0]     data_r;
    logic [15:0]     result_r;
    logic [7:0]      ident_r;
    logic            ident_ok_r;
    logic            done_r;
    logic            refused_r;
    logic [31:0]     settle_r;
    logic [2:0]      breg_r;
    logic [15:0]     bdata_r;
    logic            bwr_r;
    logic            brd_r;
    logic            got_r;
    logic            is_relay_cmd;

    assign is_relay_cmd = (reg_r == rmux_pkg::WR_OPEN) || (reg_r == rmux_pkg::WR_CLOSE);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r    <= CS_IDLE;
            cmd_r      <= rmux_pkg::CMD_READ;
            reg_r      <= 3'h0;
            data_r     <= 16'h0;
            result_r   <= 16'h0;
            ident_r    <= 8'h0;
            ident_ok_r <= 1'b0;
            done_r     <= 1'b0;
            refused_r  <= 1'b0;
            settle_r   <= 32'h0;
            breg_r     <= 3'h0;
            bdata_r    <= 16'h0;
            bwr_r      <= 1'b0;
            brd_r      <= 1'b0;
            got_r      <= 1'b0;
        end else begin
            bwr_r <= 1'b0;
            brd_r <= 1'b0;
            got_r <= brd_r;
            if (settle_r != 32'h0) begin
                settle_r <= settle_r - 32'h1;
            end
            unique case (state_r)
                CS_IDLE: begin
                    if (wr && addr == rmux_pkg::CR_DATA) begin
                        data_r <= wdata;
                    end
                    if (wr && addr == rmux_pkg::CR_CMD) begin
                        cmd_r  <= wdata[5:4];
                        reg_r  <= wdata[2:0];
                        done_r <= 1'b0;
                        state_r <= CS_POLL;
                    end
                end
                CS_POLL: begin
                    breg_r  <= rmux_pkg::RD_STATUS;
                    brd_r   <= 1'b1;
                    state_r <= CS_PWAIT;
                end
                CS_PWAIT: begin
                    if (got_r) begin
                        if (bus.rd_data[rmux_pkg::BUSY_BIT]) begin
                            state_r <= CS_POLL;
                        end else if (cmd_r == rmux_pkg::CMD_READ && reg_r == rmux_pkg::RD_RELAY
                                     && settle_r != 32'h0) begin
                            state_r <= CS_POLL;
                        end else begin
                            state_r <= CS_ISSUE;
                        end
                    end
                end
                CS_ISSUE: begin
                    breg_r    <= (cmd_r == rmux_pkg::CMD_IDENT) ? rmux_pkg::RD_IDENT : reg_r;
                    bdata_r   <= data_r;
                    refused_r <= 1'b0;
                    state_r   <= CS_WAIT;
                    if (cmd_r == rmux_pkg::CMD_WRITE) begin
                        bwr_r <= 1'b1;
                        if (is_relay_cmd) begin
                            settle_r <= SETTLE_CYCLES;
                        end
                        if (reg_r == rmux_pkg::WR_RESET) begin
                            ident_ok_r <= 1'b0;
                        end
                    end else begin
                        brd_r <= 1'b1;
                    end
                end
                CS_WAIT: begin
                    if (cmd_r == rmux_pkg::CMD_WRITE || got_r) begin
                        if (got_r) begin
                            result_r <= bus.rd_data;
                        end
                        if (got_r && cmd_r == rmux_pkg::CMD_IDENT) begin
                            ident_r    <= bus.rd_data[7:0];
                            ident_ok_r <= (bus.rd_data[2:0] != rmux_pkg::NO_TERMINAL);
                        end
                        done_r  <= 1'b1;
                        state_r <= CS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0;
        end else if (rd) begin
            unique case (addr)
                rmux_pkg::CR_DATA:   rdata <= data_r;
                rmux_pkg::CR_RESULT: rdata <= result_r;
                rmux_pkg::CR_STATUS: rdata <= {12'h0, refused_r, ident_ok_r, done_r, state_r != CS_IDLE};
                rmux_pkg::CR_IDENT:  rdata <= {8'h0, ident_r};
                default:             rdata <= 16'h0;
            endcase
        end
    end

    assign bus.reg_num    = breg_r;
    assign bus.wr_data    = bdata_r;
    assign bus.wr_stb     = bwr_r;
    assign bus.rd_stb     = brd_r;
    assign bus.slot_reset = rst;
endmodule

/* test/rmux_link_chk.sv */
// concurrent checks on the relay multiplexer backplane link
`timescale 1ns/1ps
module rmux_link_chk #(
    parameter int unsigned SETTLE_CYCLES = 8,
    parameter int unsigned ACT_CYCLES    = 5
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [2:0]  reg_num,
    input wire logic [15:0] wr_data,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [15:0] rd_data,
    input wire logic        opening_pulse,
    input wire logic        closing_pulse,
    input wire logic        slot_reset
);
    logic [15:0] since_r;
    logic [15:0] run_r;
    wire         act = opening_pulse | closing_pulse;
    wire         cmd = wr_stb && (reg_num == rmux_pkg::WR_OPEN || reg_num == rmux_pkg::WR_CLOSE);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // cycles since the last open or close command, saturating
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) since_r <= 16'hffff;
        else if (cmd) since_r <= 16'h0000;
        else if (since_r != 16'hffff) since_r <= since_r + 16'h0001;
    end
    // length of the current relay action
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) run_r <= 16'h0000;
        else if (act) run_r <= run_r + 16'h0001;
        else run_r <= 16'h0000;
    end
    a_ident_high_ones: assert property (rd_stb && reg_num == rmux_pkg::RD_IDENT |=> rd_data[15:8] == 8'hff)
        else $error("identity high byte not all ones");
    a_unused_read_ones: assert property (rd_stb && reg_num > 3'h2 |=> rd_data == rmux_pkg::ALL_ONES)
        else $error("unused read not all ones");
    a_status_only_busy: assert property (rd_stb && reg_num == rmux_pkg::RD_STATUS |=> rd_data[15:2] == 14'h0000)
        else $error("status word carries more than busy");
    a_relay_top_zero: assert property (rd_stb && reg_num == rmux_pkg::RD_RELAY |=> rd_data[15:12] == 4'h0)
        else $error("relay state uses bits above eleven");
    a_open_pulse_starts: assert property (wr_stb && reg_num == rmux_pkg::WR_OPEN |=> opening_pulse)
        else $error("open write gave no opening pulse");
    a_close_pulse_starts: assert property (wr_stb && reg_num == rmux_pkg::WR_CLOSE && !opening_pulse |=> closing_pulse)
        else $error("close write gave no closing pulse");
    a_pulses_apart: assert property (!(opening_pulse && closing_pulse))
        else $error("opening and closing overlap");
    a_reset_stops: assert property (wr_stb && reg_num == rmux_pkg::WR_RESET |=> !act)
        else $error("reset write left a relay action running");
    a_no_cmd_busy: assert property (cmd |-> !act)
        else $error("command issued during relay action");
    a_action_length: assert property ($fell(act) |-> run_r >= ACT_CYCLES - 1 && run_r <= ACT_CYCLES + 1)
        else $error("relay action of wrong length");
    a_settle_wait: assert property (rd_stb && reg_num == rmux_pkg::RD_RELAY |-> since_r >= SETTLE_CYCLES - 1)
        else $error("relay state read too soon after command");
    c_close: cover property (wr_stb && reg_num == rmux_pkg::WR_CLOSE);
    c_open: cover property (wr_stb && reg_num == rmux_pkg::WR_OPEN);
    c_reset: cover property (wr_stb && reg_num == rmux_pkg::WR_RESET);
endmodule

/* test/relay_mux_register_control_tb.sv */
// self-checking bench for the relay multiplexer register link
`timescale 1ns/1ps
module relay_mux_register_control_tb;
    localparam logic [4:0] COMP_ID = 5'h0a;  // arbitrary value
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        term_present = 1'b1;
    logic [2:0]  term_id = 3'h5;
    logic [3:0]  tree_drive;
    logic [3:0]  bank_a_drive;
    logic [3:0]  bank_b_drive;
    logic        busy;
    logic [15:0] res;
    logic [15:0] rdata2;
    logic [15:0] res2;
    logic [3:0]  tree2;
    int          failures = 0;
    int          checked = 0;
    rmux_bus_if bus ();
    rmux_bus_if bus2 ();
    rmux_accessory #(.COMPONENT_ID(COMP_ID), .SIXTY_CH(1'b0), .ACT_CYCLES(5)) i_rmux_accessory (
        .sys_clk(sys_clk), .rst(rst), .terminal_present(term_present), .terminal_id(term_id), .bus(bus),
        .tree_drive(tree_drive), .bank_a_drive(bank_a_drive), .bank_b_drive(bank_b_drive), .busy(busy));
    rmux_controller #(.SETTLE_CYCLES(8)) i_rmux_controller (
        .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus(bus));
    // sixty channel pair runs the same command stream in lockstep
    rmux_accessory #(.COMPONENT_ID(COMP_ID), .SIXTY_CH(1'b1), .ACT_CYCLES(5)) i_rmux_accessory_sixty (
        .sys_clk(sys_clk), .rst(rst), .terminal_present(term_present), .terminal_id(term_id), .bus(bus2),
        .tree_drive(tree2), .bank_a_drive(), .bank_b_drive(), .busy());
    rmux_controller #(.SETTLE_CYCLES(8)) i_rmux_controller_sixty (
        .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata2), .bus(bus2));
    rmux_link_chk #(.SETTLE_CYCLES(8), .ACT_CYCLES(5)) i_rmux_link_chk (
        .sys_clk(sys_clk), .rst(rst), .reg_num(bus.reg_num), .wr_data(bus.wr_data), .wr_stb(bus.wr_stb),
        .rd_stb(bus.rd_stb), .rd_data(bus.rd_data), .opening_pulse(bus.opening_pulse),
        .closing_pulse(bus.closing_pulse), .slot_reset(bus.slot_reset));
    always #50 sys_clk = ~sys_clk;
    task automatic summarize;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic cw(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic cr(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
        res2 = rdata2;
    endtask
    // one controller command, polled until done
    task automatic op(input logic [1:0] c, input logic [2:0] r, input logic [15:0] d);
        int n;
        cw(rmux_pkg::CR_DATA, d);
        cw(rmux_pkg::CR_CMD, {10'h000, c, 1'b0, r});
        n = 0;
        res = 16'h0001;
        while (!(res[0] === 1'b0 && res[1] === 1'b1) && n < 500) begin
            cr(rmux_pkg::CR_STATUS, res);
            n++;
        end
        if (n >= 500) cmp(16'h0000, 16'h0001, "command hang");
        cr(rmux_pkg::CR_RESULT, res);
    endtask
    task automatic rchk(input logic [2:0] r, input logic [15:0] exp, input string what);
        op(rmux_pkg::CMD_READ, r, 16'h0000);
        cmp(res, exp, what);
    endtask
    task automatic wchk(input logic [2:0] r, input logic [15:0] d, input logic [15:0] exp,
                        input logic [15:0] exp2, input string what);
        op(rmux_pkg::CMD_WRITE, r, d);
        rchk(rmux_pkg::RD_RELAY, exp, what);
        cmp(res2, exp2, "sixty channel state");
        cmp({4'h0, tree_drive, bank_b_drive, bank_a_drive}, exp, "relay drives");
        cmp({12'h000, tree2}, {12'h000, exp2[11:8]}, "sixty tree drive");
        cmp({15'h0000, busy}, 16'h0000, "busy after command");
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rchk(rmux_pkg::RD_IDENT, {8'hff, COMP_ID, 3'h5}, "identity");
        term_present <= 1'b0;
        rchk(rmux_pkg::RD_IDENT, {8'hff, COMP_ID, 3'h7}, "identity no terminal");
        term_present <= 1'b1;
        op(rmux_pkg::CMD_IDENT, 3'h0, 16'h0000);
        cmp(res, {8'hff, COMP_ID, 3'h5}, "identity command");
        cr(rmux_pkg::CR_IDENT, res);
        cmp(res, {8'h00, COMP_ID, 3'h5}, "identity latched");
        cr(rmux_pkg::CR_STATUS, res);
        cmp(res, 16'h0006, "terminal accepted");
        rchk(rmux_pkg::RD_RELAY, 16'h00cc, "state after reset");
        rchk(rmux_pkg::RD_STATUS, 16'h0000, "status idle");
        for (int r = 3; r < 8; r++) rchk(3'(r), 16'hffff, "unused read");
        $display("register read test done");
        wchk(rmux_pkg::WR_CLOSE, 16'h1000, 16'h00c0, 16'h00c0, "close 00");
        wchk(rmux_pkg::WR_CLOSE, 16'h1001, 16'h00c1, 16'h00c1, "close 01");
        wchk(rmux_pkg::WR_CLOSE, 16'h655f, 16'h0551, 16'h0551, "close tree and bank b");
        wchk(rmux_pkg::WR_CLOSE, 16'h1803, 16'h0553, 16'h09c3, "close one sense tree");
        wchk(3'h4, 16'h1009, 16'h0553, 16'h09c3, "unused write");
        wchk(rmux_pkg::WR_OPEN, 16'h4100, 16'h0453, 16'h08c3, "open tree");
        wchk(rmux_pkg::WR_OPEN, 16'h1000, 16'h045c, 16'h08cc, "open bank a");
        wchk(rmux_pkg::WR_RESET, 16'h1234, 16'h00cc, 16'h00cc, "reset write");
        cr(rmux_pkg::CR_STATUS, res);
        cmp(res, 16'h0002, "identity cleared by reset");
        $display("relay command test done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("ERROR %0t: watchdog expired", $time);
        summarize();
    end
endmodule
